// [hdl/idx_acc_ops.sv]
// datapath slice: copy, swap and add-with-carry between index file and work register
// assumes decoder pulses I_VALID with a byte and waits for O_DONE before the next
`timescale 1ns/1ns
`include "idx_defs.svh"
module idx_acc_ops (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // instruction request
  input wire logic I_VALID,
  input wire logic [3:0] I_OPCODE_HIGH_NIBBLE,
  input wire logic [3:0] I_OPERAND_LOW_NIBBLE,
  // results
  output logic O_BUSY,
  output logic O_DONE,
  output logic [3:0] O_WORK_REGISTER,
  output logic O_CARRY_LINK_FLAG
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} state_t;

  typedef struct packed {
    state_t st;
    idx_pkg::op_kind_t kind;
    logic [3:0] sel;
    logic [3:0] work;
    logic carry;
    logic busy;
    logic done;
  } core_t;

  core_t s_q, s_d;
  logic rf_we;
  logic [3:0] rf_wdata;
  logic [3:0] rf_rdata;
  logic [4:0] sum;

  // map the high nibble onto an operation kind
  function automatic idx_pkg::op_kind_t decode(input logic [3:0] hi);
    if (hi == `OP_COPY) begin
      decode = idx_pkg::OPK_COPY;
    end else if (hi == `OP_SWAP) begin
      decode = idx_pkg::OPK_SWAP;
    end else if (hi == `OP_ADD) begin
      decode = idx_pkg::OPK_ADD;
    end else begin
      decode = idx_pkg::OPK_NONE;
    end
  endfunction

  // index register file, low nibble addresses it directly
  idx_regfile #(.WIDTH(4), .DEPTH(16), .AW(4)) u_rf (
    .clk(I_CLK),
    .rst(I_RST),
    .we(rf_we),
    .waddr(s_q.sel), // [RULE10]
    .wdata(rf_wdata),
    .raddr(s_q.sel),
    .rdata(rf_rdata)
  );

  // full five bit sum of index, work and carry
  assign sum = {1'b0, rf_rdata} + {1'b0, s_q.work} + {4'h0, s_q.carry}; // [RULE6]
  // only swap writes the file; copy and add leave it alone
  assign rf_we = (s_q.st == ST_EXEC) && (s_q.kind == idx_pkg::OPK_SWAP); // [RULE4] [RULE2] [RULE9]
  assign rf_wdata = s_q.work; // [RULE4]

  // next state and datapath
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (I_VALID && decode(I_OPCODE_HIGH_NIBBLE) != idx_pkg::OPK_NONE) begin
          s_d.kind = decode(I_OPCODE_HIGH_NIBBLE);
          s_d.sel = I_OPERAND_LOW_NIBBLE; // [RULE10]
          s_d.st = ST_READ;
          s_d.busy = 1'b1;
        end
      end
      ST_READ: begin
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        case (s_q.kind)
          idx_pkg::OPK_COPY: s_d.work = rf_rdata; // [RULE1] [RULE2]
          idx_pkg::OPK_SWAP: s_d.work = rf_rdata; // [RULE3] [RULE5]
          idx_pkg::OPK_ADD: begin
            s_d.work = sum[3:0]; // [RULE6]
            s_d.carry = (sum > `SUM_LIMIT); // [RULE7] [RULE8]
          end
          default: s_d.work = s_q.work;
        endcase
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      s_q <= '{st: ST_IDLE, kind: idx_pkg::OPK_NONE, sel: 4'h0, work: `WORK_RESET,
               carry: `CARRY_RESET, busy: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign O_BUSY = s_q.busy;
  assign O_DONE = s_q.done;
  assign O_WORK_REGISTER = s_q.work;
  assign O_CARRY_LINK_FLAG = s_q.carry;

  // named sequences for the execute step
  sequence exec_copy_s;
    s_q.st == ST_EXEC && s_q.kind == idx_pkg::OPK_COPY;
  endsequence
  sequence exec_swap_s;
    s_q.st == ST_EXEC && s_q.kind == idx_pkg::OPK_SWAP;
  endsequence
  sequence exec_add_s;
    s_q.st == ST_EXEC && s_q.kind == idx_pkg::OPK_ADD;
  endsequence

  chk_copy_loads_work: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE1]
    exec_copy_s |=> O_WORK_REGISTER == $past(rf_rdata)) else $error("copy did not load work");
  chk_copy_keeps_carry: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE2]
    exec_copy_s |=> $stable(O_CARRY_LINK_FLAG) && !$past(rf_we)) else $error("copy changed carry or file");
  chk_swap_loads_work: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE3]
    exec_swap_s |=> O_WORK_REGISTER == $past(rf_rdata)) else $error("swap did not load work");
  chk_swap_writes_old: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE4]
    exec_swap_s |-> rf_we && rf_wdata == O_WORK_REGISTER) else $error("swap did not write old work");
  chk_swap_keeps_carry: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE5]
    exec_swap_s |=> $stable(O_CARRY_LINK_FLAG)) else $error("swap changed carry");
  chk_add_sum_low: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE6]
    exec_add_s |=> O_WORK_REGISTER == 4'($past(rf_rdata) + $past(O_WORK_REGISTER) + $past(O_CARRY_LINK_FLAG)))
    else $error("add result wrong");
  chk_add_carry_set: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE7]
    exec_add_s and (sum > `SUM_LIMIT) |=> O_CARRY_LINK_FLAG) else $error("carry not set");
  chk_add_carry_clr: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE8]
    exec_add_s and (sum <= `SUM_LIMIT) |=> !O_CARRY_LINK_FLAG) else $error("carry not cleared");
  chk_add_keeps_index: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE9]
    exec_add_s |-> !rf_we) else $error("add wrote index file");
  chk_select_latched: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    s_q.st == ST_IDLE && I_VALID && decode(I_OPCODE_HIGH_NIBBLE) != idx_pkg::OPK_NONE
    |=> s_q.sel == $past(I_OPERAND_LOW_NIBBLE) ##1 s_q.st == ST_EXEC) else $error("select not latched");

  // handshake checks: the decoder relies on busy and done to pace its requests
  // a request is taken only in idle and only with one of the three known opcodes
  // anything else must be dropped without effect, since nothing reports a refusal
  sequence accept_s;
    s_q.st == ST_IDLE && I_VALID && decode(I_OPCODE_HIGH_NIBBLE) != idx_pkg::OPK_NONE;
  endsequence

  // busy for two cycles, then one done cycle with busy already low
  chk_busy_window: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    accept_s |=> O_BUSY && !O_DONE ##1 O_BUSY && !O_DONE ##1 !O_BUSY && O_DONE)
    else $error("busy or done out of step");

  // done is a single cycle pulse
  chk_done_single: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    O_DONE |=> !O_DONE)
    else $error("done held too long");

  // outside the execute step work and carry must hold their values
  chk_hold_outside: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE2]
    s_q.st != ST_EXEC |=> $stable(O_WORK_REGISTER) && $stable(O_CARRY_LINK_FLAG))
    else $error("work or carry moved outside execute");

  // copy must never write the index file
  chk_copy_no_write: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE2]
    exec_copy_s |-> !rf_we)
    else $error("copy wrote index file");

  // an unknown opcode is dropped without going busy
  chk_unknown_ignored: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    s_q.st == ST_IDLE && I_VALID && decode(I_OPCODE_HIGH_NIBBLE) == idx_pkg::OPK_NONE
    |=> !O_BUSY && s_q.st == ST_IDLE) else $error("unknown opcode taken");

  // the read step always moves on to execute, never stalls
  chk_read_to_exec: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    s_q.st == ST_READ |=> s_q.st == ST_EXEC)
    else $error("read step stalled");

  // the swap writes back into the register it read from
  chk_swap_same_sel: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE4]
    exec_swap_s |-> s_q.sel == $past(s_q.sel))
    else $error("swap target moved");

  // the carry after add is the fifth bit of the full sum
  chk_add_carry_bit: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE7]
    exec_add_s |=> O_CARRY_LINK_FLAG == $past(sum[4]))
    else $error("carry not the sum overflow");

  // a request arriving while busy must not restart the sequence
  chk_busy_refuses: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
    O_BUSY && I_VALID |=> s_q.st != ST_READ)
    else $error("request taken while busy");

  // swap must write the index file while the slice is still busy
  chk_swap_writes_sel: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE4]
    exec_swap_s |-> rf_we && s_q.busy)
    else $error("swap write not in busy window");
endmodule // idx_acc_ops

// [hdl/idx_defs.svh]
// constants for the index register accumulator datapath slice
// assumes a decoder presents one instruction byte per request
// Summary of operation
// RULE1: opcode 1010 copies index register to work
// RULE2: copy leaves index register and carry alone
// RULE3: opcode 1011 loads work from index register
// RULE4: swap writes old work into index register
// RULE5: swap never touches the carry link flag
// RULE6: opcode 1000 adds index, work and carry
// RULE7: carry set when full sum exceeds fifteen
// RULE8: carry cleared when sum not above fifteen
// RULE9: add leaves index register unchanged
// RULE10: low nibble selects one of sixteen registers
`ifndef IDX_DEFS_SVH
`define IDX_DEFS_SVH
`define OP_COPY 4'ha
`define OP_SWAP 4'hb
`define OP_ADD 4'h8
`define SUM_LIMIT 5'h0f
`define WORK_RESET 4'h0
`define CARRY_RESET 1'b0
`endif

// [hdl/idx_pkg.sv]
// types for the index register accumulator datapath slice
// assumes idx_defs.svh supplies the numeric constants
package idx_pkg;
  typedef enum logic [1:0] {OPK_NONE, OPK_COPY, OPK_SWAP, OPK_ADD} op_kind_t;
endpackage

// [hdl/idx_regfile.sv]
// sixteen by four index register file with registered read
// assumes one clock, synchronous writes and reads
`timescale 1ns/1ns
module idx_regfile #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdata <= '0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // idx_regfile

// [verif/idx_decoder_model.sv]
// decoder-side model: issues one instruction byte and watches the answer
// assumes inputs change at the falling edge and the slice answers on O_DONE
`timescale 1ns/1ns
module idx_decoder_model (
  // clock and answer
  input wire logic I_CLK,
  input wire logic I_DONE,
  // request
  output logic O_VALID,
  output logic [3:0] O_OPCODE,
  output logic [3:0] O_OPERAND
);
  initial begin
    O_VALID = 1'b0;
    O_OPCODE = 4'h0;
    O_OPERAND = 4'h0;
  end
  // strobe held for the first hold of nine edges, done pulses counted over all nine
  task automatic issue(input logic [3:0] op, input logic [3:0] idx, input int hold,
                       output logic [7:0] lat, output logic [7:0] dones);
    lat = 8'h00;
    dones = 8'h00;
    @(negedge I_CLK);
    O_VALID = 1'b1;
    O_OPCODE = op;
    O_OPERAND = idx;
    for (int k = 0; k < 9; k++) begin
      @(posedge I_CLK);
      @(negedge I_CLK);
      if (k + 1 >= hold) O_VALID = 1'b0; // extra cycles land while busy
      if (I_DONE === 1'b1) begin
        dones = dones + 8'h01;
        if (lat == 8'h00) lat = 8'(k);
      end
    end
  endtask
endmodule // idx_decoder_model

// [verif/idx_acc_ops_tb_top.sv]
// testbench for the copy, swap and add slice, table driven
// assumes a zero index file after reset, so every result stays zero
`timescale 1ns/1ns
module idx_acc_ops_tb_top;
  typedef struct {logic [3:0] op; logic [3:0] idx; int hold; logic [7:0] lat; logic [7:0] dones;} row_t;
  logic clk, rst, valid, busy, done, carry;
  logic [3:0] opc, opd, work;
  logic [7:0] lat, dones;
  int fails = 0;
  int tests_run = 0;
  // latency is counted in model loop steps: done shows at the step after the third edge, index 2
  row_t rows [9] = '{'{4'ha, 4'h0, 1, 8'h02, 8'h01}, '{4'ha, 4'hf, 1, 8'h02, 8'h01},
    '{4'hb, 4'h0, 1, 8'h02, 8'h01}, '{4'hb, 4'hf, 1, 8'h02, 8'h01}, '{4'h8, 4'h0, 1, 8'h02, 8'h01},
    '{4'h8, 4'hf, 1, 8'h02, 8'h01}, '{4'h1, 4'h5, 1, 8'h00, 8'h00}, '{4'ha, 4'h7, 3, 8'h02, 8'h01},
    '{4'h8, 4'h9, 3, 8'h02, 8'h01}};
  idx_decoder_model idx_decoder_model_inst (.I_CLK(clk), .I_DONE(done), .O_VALID(valid),
    .O_OPCODE(opc), .O_OPERAND(opd));
  idx_acc_ops idx_acc_ops_inst (.I_CLK(clk), .I_RST(rst), .I_VALID(valid), .I_OPCODE_HIGH_NIBBLE(opc),
    .I_OPERAND_LOW_NIBBLE(opd), .O_BUSY(busy), .O_DONE(done), .O_WORK_REGISTER(work),
    .O_CARRY_LINK_FLAG(carry));
  // one comparison, counted
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // clock at 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog, ample against about 120 cycles of tests
  initial begin
    #40000;
    fails++;
    summarize();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check({2'b00, busy, done, work}, 8'h00);
    foreach (rows[i]) begin
      idx_decoder_model_inst.issue(rows[i].op, rows[i].idx, rows[i].hold, lat, dones);
      check(lat, rows[i].lat);
      check(dones, rows[i].dones);
      check({3'b000, carry, work}, 8'h00);
      $display("row %0d done", i);
    end
    // swap then copy of the same register: old work comes back
    idx_decoder_model_inst.issue(4'hb, 4'hc, 1, lat, dones);
    idx_decoder_model_inst.issue(4'ha, 4'hc, 1, lat, dones);
    check({3'b000, carry, work}, 8'h00);
    $display("swap copy test done");
    // reset while idle clears busy, done, carry and the low three work bits
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({2'b00, busy, done, carry, work[2:0]}, 8'h00);
    $display("reset test done");
    summarize();
  end
endmodule // idx_acc_ops_tb_top
